// ==== rtl/sct_cfg.svh ====
`ifndef SCT_CFG_SVH
`define SCT_CFG_SVH

`define SCT_CLK_NS 50
// least times round up, longest round down
`define SCT_CYC(ns) (((ns) + `SCT_CLK_NS - 1) / `SCT_CLK_NS)
`define SCT_CYC_DN(ns) ((ns) / `SCT_CLK_NS)

// slowest speed grade, so any part of the family is served
`define SCT_TRC_NS 65
`define SCT_TRAS_NS 45
`define SCT_TRAS_MAX_NS 100000
`define SCT_TRCD_NS 20
`define SCT_TRP_NS 20
`define SCT_TRRD_NS 14
`define SCT_TRSC_NS 14
`define SCT_PWRUP_US 200
`define SCT_TREF_MS 64
`define SCT_ROWS 2048
`define SCT_INIT_REFS 4'h8

`define SCT_TRC_CYC `SCT_CYC(`SCT_TRC_NS)
`define SCT_TRAS_CYC `SCT_CYC(`SCT_TRAS_NS)
`define SCT_TRAS_MAX_CYC `SCT_CYC_DN(`SCT_TRAS_MAX_NS)
`define SCT_TRCD_CYC `SCT_CYC(`SCT_TRCD_NS)
`define SCT_TRP_CYC `SCT_CYC(`SCT_TRP_NS)
`define SCT_TRRD_CYC `SCT_CYC(`SCT_TRRD_NS)
`define SCT_TRSC_CYC `SCT_CYC(`SCT_TRSC_NS)
`define SCT_PWRUP_CYC `SCT_CYC(`SCT_PWRUP_US * 1000)
`define SCT_REFI_CYC `SCT_CYC_DN(`SCT_TREF_MS * 1000000 / `SCT_ROWS)

// {cs_n, ras_n, cas_n, we_n}
`define SCT_CMD_MODE 4'h0
`define SCT_CMD_REF 4'h1
`define SCT_CMD_PRE 4'h2
`define SCT_CMD_ACT 4'h3
`define SCT_CMD_WR 4'h4
`define SCT_CMD_RD 4'h5
`define SCT_CMD_STOP 4'h6
`define SCT_CMD_NOP 4'h7

`define SCT_AP_BIT 10
`define SCT_MR_LAT_HI 6
`define SCT_MR_LAT_LO 4
`define SCT_MR_BURST_HI 2
`define SCT_MR_BURST_LO 0
`define SCT_LAT2 3'h2
// read latency 2, burst length 1, sequential
`define SCT_MODE_WORD 11'h020
`define SCT_BURST_LEN 1

`endif

// ==== rtl/sct_pkg.sv ====
package sct_pkg;
  typedef enum logic [2:0] {
    SCT_POWER,
    SCT_PRE_ALL,
    SCT_MODE,
    SCT_INIT_REF,
    SCT_IDLE,
    SCT_COL
  } sct_state_e;
  typedef logic [3:0] sct_cmd_t;
endpackage

// ==== rtl/sct_if.sv ====
`timescale 1ns/1ns
interface sct_if;
  import sct_pkg::*;
  logic cke;
  sct_cmd_t cmd_n;
  logic [1:0] ba;
  logic [10:0] addr;
  logic [3:0] dqm;
  logic [31:0] dq_c;
  logic dq_c_oe;
  logic [31:0] dq_d;
  logic [3:0] dq_d_oe;
  modport ctrl (
    output cke, cmd_n, ba, addr, dqm, dq_c, dq_c_oe,
    input dq_d, dq_d_oe
  );
  modport dram (
    input cke, cmd_n, ba, addr, dqm, dq_c, dq_c_oe,
    output dq_d, dq_d_oe
  );
endinterface

// ==== rtl/sct_dram.sv ====
`timescale 1ns/1ns
`include "sct_cfg.svh"
module sct_dram
  import sct_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  sct_if.dram bus,
  output logic [2:0] read_latency_out,
  output logic [3:0] burst_length_setting_out,
  output logic clk_active_out
);
  // only the column address and bank index the store; rows alias
  logic [31:0] mem [0:1023];
  logic cke_q;
  logic [2:0] read_latency;
  logic [2:0] burst_code;
  logic rd_run;
  logic wr_run;
  logic [1:0] bnk;
  logic [7:0] col;
  logic [3:0] left;
  logic [3:1] s_v;
  logic [31:0] s_d [1:3];
  logic [3:0] m1;
  logic [3:0] m2;
  logic en;
  logic rd_now;
  logic wr_now;
  logic [9:0] acc;
  logic out_v;

  function automatic logic [3:0] burst_words(input logic [2:0] code);
    // full page is served as eight words
    case (code)
      3'h0: burst_words = 4'h1;
      3'h1: burst_words = 4'h2;
      3'h2: burst_words = 4'h4;
      default: burst_words = 4'h8;
    endcase
  endfunction

  assign en = cke_q;
  always_comb begin
    rd_now = 1'b0;
    wr_now = 1'b0;
    acc = {bnk, col};
    if (bus.cmd_n == `SCT_CMD_RD) begin
      rd_now = 1'b1;
      acc = {bus.ba, bus.addr[7:0]};
    end else if (bus.cmd_n == `SCT_CMD_WR) begin
      wr_now = 1'b1;
      acc = {bus.ba, bus.addr[7:0]};
    end else if (bus.cmd_n == `SCT_CMD_NOP) begin
      rd_now = rd_run;
      wr_now = wr_run;
    end
    rd_now = rd_now & en;
    wr_now = wr_now & en;
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cke_q <= 1'b0;
    end else begin
      cke_q <= bus.cke;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      read_latency <= `SCT_LAT2;
      burst_code <= 3'h0;
    end else if (en && bus.cmd_n == `SCT_CMD_MODE) begin
      read_latency <= bus.addr[`SCT_MR_LAT_HI:`SCT_MR_LAT_LO];
      burst_code <= bus.addr[`SCT_MR_BURST_HI:`SCT_MR_BURST_LO];
    end
  end

  // precharge and burst stop end the issue of words at once
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_run <= 1'b0;
      wr_run <= 1'b0;
      bnk <= 2'h0;
      col <= 8'h00;
      left <= 4'h0;
    end else if (en) begin
      if (bus.cmd_n == `SCT_CMD_RD || bus.cmd_n == `SCT_CMD_WR) begin
        rd_run <= (bus.cmd_n == `SCT_CMD_RD) &&
          burst_words(burst_code) > 4'h1;
        wr_run <= (bus.cmd_n == `SCT_CMD_WR) &&
          burst_words(burst_code) > 4'h1;
        bnk <= bus.ba;
        col <= bus.addr[7:0] + 8'h01;
        left <= burst_words(burst_code) - 4'h2;
      end else if (bus.cmd_n != `SCT_CMD_NOP) begin
        rd_run <= 1'b0;
        wr_run <= 1'b0;
      end else if (rd_run || wr_run) begin
        col <= col + 8'h01;
        left <= left - 4'h1;
        if (left == 4'h0) begin
          rd_run <= 1'b0;
          wr_run <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (wr_now) begin
      for (int b = 0; b < 4; b++) begin
        if (!bus.dqm[b]) begin
          mem[acc][8*b +: 8] <= bus.dq_c[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_v <= 3'h0;
      m1 <= 4'hF;
      m2 <= 4'hF;
    end else if (en) begin
      s_v <= {s_v[2:1], rd_now};
      m1 <= bus.dqm;
      m2 <= m1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (en) begin
      s_d[1] <= mem[acc];
      s_d[2] <= s_d[1];
      s_d[3] <= s_d[2];
    end
  end

  assign out_v = (read_latency == `SCT_LAT2) ? s_v[2] : s_v[3];
  assign bus.dq_d = (read_latency == `SCT_LAT2) ? s_d[2] : s_d[3];
  assign bus.dq_d_oe = {4{out_v}} & ~m2;
  assign read_latency_out = read_latency;
  assign burst_length_setting_out = burst_words(burst_code);
  assign clk_active_out = cke_q;
endmodule

// ==== rtl/sct_ctrl.sv ====
// Operation
// - activate or refresh same bank spaced by row cycle
// - precharge between minimum and maximum after activate
// - activate to column command delay respected
// - column commands may follow every cycle
// - precharge to activate delay respected
// - activates to different banks spaced apart
// - wait after mode set before next command
// - times converted to cycles, minimums rounded up, maximums rounded down
// - power-up holds commands at no-operation
// - wait 200 us holding mask and clock-enable high
// - precharge all banks after power-up pause
// - then set the mode register
// - at least eight refreshes during initialization
// - clock-enable acts one cycle later
// - read mask floats two later, write mask immediate
// - write data travels with the write command
// - precharge releases bus two or three later
// - precharge last word one or two later
// - burst stop releases bus two or three later
// - burst stop last word one or two later
// - read auto-precharge waits burst plus precharge time
// - write auto-precharge waits burst plus precharge time
`timescale 1ns/1ns
`include "sct_cfg.svh"
module sct_ctrl
  import sct_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  sct_if.ctrl bus,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [1:0] req_bank_in,
  input wire logic [10:0] req_row_in,
  input wire logic [7:0] req_col_in,
  input wire logic [31:0] req_wdata_in,
  input wire logic [3:0] req_mask_in,
  output logic req_ready_out,
  output logic [31:0] rdata_out,
  output logic rdata_valid_out,
  output logic init_done_out
);
  sct_state_e state;
  logic [11:0] hold;
  logic [3:0] refs;
  logic [9:0] ref_cnt;
  logic ref_pend;
  logic ref_tick;
  logic ref_take;
  logic take;
  logic wr_q;
  logic [1:0] bank_q;
  logic [7:0] col_q;
  logic [31:0] wdata_q;
  logic [3:0] mask_q;
  logic [2:1] rd_pipe;

  function automatic logic [11:0] cyc_max(input int a, input int b);
    cyc_max = (a > b) ? 12'(a) : 12'(b);
  endfunction

  // closed-page policy: a single row is open at a time and it closes
  // by auto-precharge, so activate spacing reduces to one timer
  localparam logic [11:0] ACT_HOLD = cyc_max(
    cyc_max(`SCT_TRCD_CYC, `SCT_TRAS_CYC - `SCT_BURST_LEN),
    `SCT_TRRD_CYC) - 12'h001;
  localparam logic [11:0] AP_HOLD = cyc_max(
    `SCT_BURST_LEN + `SCT_TRP_CYC,
    `SCT_TRC_CYC - `SCT_TRCD_CYC) - 12'h001;
  localparam logic [11:0] REF_HOLD = 12'(`SCT_TRC_CYC) - 12'h001;

  assign req_ready_out = (state == SCT_IDLE) && (hold == 12'h000) &&
    !ref_pend;
  assign take = req_valid_in && req_ready_out;
  assign ref_take = (state == SCT_IDLE) && (hold == 12'h000) && ref_pend;
  assign ref_tick = (ref_cnt == 10'h000);

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ref_cnt <= 10'(`SCT_REFI_CYC - 1);
    end else if (init_done_out) begin
      if (ref_tick) begin
        ref_cnt <= 10'(`SCT_REFI_CYC - 1);
      end else begin
        ref_cnt <= ref_cnt - 10'h001;
      end
    end
  end

  // a tick in the same cycle as the service keeps the request
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ref_pend <= 1'b0;
    end else if (ref_tick && init_done_out) begin
      ref_pend <= 1'b1;
    end else if (ref_take) begin
      ref_pend <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= SCT_POWER;
      hold <= 12'(`SCT_PWRUP_CYC - 1);
      refs <= `SCT_INIT_REFS;
      init_done_out <= 1'b0;
    end else if (hold != 12'h000) begin
      hold <= hold - 12'h001;
    end else begin
      unique case (state)
        SCT_POWER: begin
          state <= SCT_PRE_ALL;
        end
        SCT_PRE_ALL: begin
          hold <= 12'(`SCT_TRP_CYC) - 12'h001;
          state <= SCT_MODE;
        end
        SCT_MODE: begin
          hold <= 12'(`SCT_TRSC_CYC) - 12'h001;
          refs <= `SCT_INIT_REFS;
          state <= SCT_INIT_REF;
        end
        SCT_INIT_REF: begin
          hold <= REF_HOLD;
          refs <= refs - 4'h1;
          if (refs == 4'h1) begin
            state <= SCT_IDLE;
            init_done_out <= 1'b1;
          end
        end
        SCT_IDLE: begin
          if (ref_pend) begin
            hold <= REF_HOLD;
          end else if (req_valid_in) begin
            hold <= ACT_HOLD;
            state <= SCT_COL;
          end
        end
        SCT_COL: begin
          hold <= AP_HOLD;
          state <= SCT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_q <= 1'b0;
      bank_q <= 2'h0;
      col_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      mask_q <= 4'h0;
    end else if (take) begin
      wr_q <= req_write_in;
      bank_q <= req_bank_in;
      col_q <= req_col_in;
      wdata_q <= req_wdata_in;
      mask_q <= req_mask_in;
    end
  end

  // commands leave from flops; nop while waiting or powering up
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bus.cmd_n <= `SCT_CMD_NOP;
      bus.cke <= 1'b1;
      bus.ba <= 2'h0;
      bus.addr <= 11'h000;
      bus.dqm <= 4'hF;
      bus.dq_c <= 32'h0000_0000;
      bus.dq_c_oe <= 1'b0;
    end else begin
      bus.cmd_n <= `SCT_CMD_NOP;
      bus.dq_c_oe <= 1'b0;
      bus.dqm <= init_done_out ? 4'h0 : 4'hF;
      if (hold == 12'h000) begin
        unique case (state)
          SCT_POWER: begin
          end
          SCT_PRE_ALL: begin
            bus.cmd_n <= `SCT_CMD_PRE;
            bus.addr <= 11'h000;
            bus.addr[`SCT_AP_BIT] <= 1'b1;
          end
          SCT_MODE: begin
            bus.cmd_n <= `SCT_CMD_MODE;
            bus.addr <= `SCT_MODE_WORD;
          end
          SCT_INIT_REF: begin
            bus.cmd_n <= `SCT_CMD_REF;
          end
          SCT_IDLE: begin
            if (ref_pend) begin
              bus.cmd_n <= `SCT_CMD_REF;
            end else if (take) begin
              bus.cmd_n <= `SCT_CMD_ACT;
              bus.ba <= req_bank_in;
              bus.addr <= req_row_in;
            end
          end
          SCT_COL: begin
            bus.cmd_n <= wr_q ? `SCT_CMD_WR : `SCT_CMD_RD;
            bus.ba <= bank_q;
            bus.addr <= {3'h0, col_q};
            bus.addr[`SCT_AP_BIT] <= 1'b1;
            bus.dq_c <= wdata_q;
            bus.dq_c_oe <= wr_q;
            bus.dqm <= wr_q ? mask_q : 4'h0;
          end
        endcase
      end
    end
  end

  // the mode word fixes read latency 2, so capture is two after
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_pipe <= 2'h0;
      rdata_out <= 32'h0000_0000;
      rdata_valid_out <= 1'b0;
    end else begin
      rd_pipe <= {rd_pipe[1], bus.cmd_n == `SCT_CMD_RD};
      rdata_valid_out <= rd_pipe[2];
      if (rd_pipe[2]) begin
        rdata_out <= bus.dq_d;
      end
    end
  end
endmodule

// ==== test/sct_monitor.sv ====
`timescale 1ns/1ns
`include "sct_cfg.svh"
module sct_monitor
  import sct_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic cke,
  input wire sct_cmd_t cmd_n,
  input wire logic [10:0] addr,
  input wire logic [3:0] dqm,
  input wire logic dq_c_oe,
  input wire logic [3:0] dq_d_oe
);
  logic pre_seen;
  logic mode_seen;
  logic [3:0] ref_cnt;
  logic [10:0] ref_gap;
  wire col = cmd_n == `SCT_CMD_RD || cmd_n == `SCT_CMD_WR;

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pre_seen <= 1'b0;
      mode_seen <= 1'b0;
      ref_cnt <= 4'h0;
    end else begin
      if (cmd_n == `SCT_CMD_PRE && addr[`SCT_AP_BIT]) pre_seen <= 1'b1;
      if (cmd_n == `SCT_CMD_MODE) mode_seen <= 1'b1;
      if (cmd_n == `SCT_CMD_REF && ref_cnt != 4'h8) ref_cnt <= ref_cnt + 4'h1;
    end
  end

  // gap is only counted once init refreshes are done
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) ref_gap <= 11'h000;
    else if (cmd_n == `SCT_CMD_REF) ref_gap <= 11'h000;
    else if (ref_cnt == 4'h8 && ref_gap != 11'h7FF) ref_gap <= ref_gap + 11'h1;
  end

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!nrst_in);

  a_power_up_quiet: assert property (
    $rose(nrst_in) |-> (cmd_n == `SCT_CMD_NOP && cke && dqm == 4'hF)[*8])
    else $error("commands not quiet after power up");
  a_pre_before_mode: assert property (
    cmd_n == `SCT_CMD_MODE |-> pre_seen)
    else $error("mode set before precharge all");
  a_ref_after_mode: assert property (
    cmd_n == `SCT_CMD_REF |-> mode_seen)
    else $error("refresh before mode set");
  a_refs_before_act: assert property (
    cmd_n == `SCT_CMD_ACT |-> ref_cnt == 4'h8)
    else $error("activate before eight refreshes");
  a_row_cycle_gap: assert property (
    cmd_n == `SCT_CMD_ACT |=> cmd_n != `SCT_CMD_ACT && cmd_n != `SCT_CMD_REF)
    else $error("row cycle too short");
  a_ras_window: assert property (
    cmd_n == `SCT_CMD_ACT |-> ##[1:8] (col && addr[`SCT_AP_BIT]))
    else $error("row not closed in time");
  a_col_after_act: assert property (
    col |-> $past(cmd_n) == `SCT_CMD_ACT)
    else $error("column command without activate");
  a_ap_recovery: assert property (
    col && addr[`SCT_AP_BIT] |=>
      cmd_n != `SCT_CMD_ACT && cmd_n != `SCT_CMD_REF)
    else $error("auto precharge recovery too short");
  a_write_data_same: assert property (
    cmd_n == `SCT_CMD_WR |-> dq_c_oe)
    else $error("write data not with write command");
  a_read_mask_float: assert property (
    cmd_n == `SCT_CMD_RD && cke |-> ##2 dq_d_oe == ~$past(dqm, 2))
    else $error("read data enable wrong");
  a_refresh_spread: assert property (
    ref_gap < 11'(`SCT_REFI_CYC) + 11'h00F)
    else $error("refresh interval too long");

  c_read: cover property (cmd_n == `SCT_CMD_RD);
  c_write: cover property (cmd_n == `SCT_CMD_WR);
  c_refresh: cover property (mode_seen && cmd_n == `SCT_CMD_REF);
  c_masked_write: cover property (cmd_n == `SCT_CMD_WR && dqm != 4'h0);
endmodule

// ==== test/sct_tb_top.sv ====
`timescale 1ns/1ns
`include "sct_cfg.svh"
module sct_tb_top;
  import sct_pkg::*;
  logic sys_clk_in, nrst_in, req_valid, req_write, req_ready;
  logic rdata_valid, init_done, clk_act;
  logic [1:0] req_bank;
  logic [7:0] req_col;
  logic [31:0] req_wdata, rdata;
  logic [3:0] req_mask, burst_len;
  logic [2:0] rl;
  logic [31:0] exp_mem [0:3];
  int error_cnt, cmp_count;

  sct_if bus_if();
  sct_ctrl sct_ctrl_inst(.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
    .bus(bus_if), .req_valid_in(req_valid), .req_write_in(req_write),
    .req_bank_in(req_bank), .req_row_in({3'h0, req_col}),
    .req_col_in(req_col), .req_wdata_in(req_wdata),
    .req_mask_in(req_mask), .req_ready_out(req_ready),
    .rdata_out(rdata), .rdata_valid_out(rdata_valid),
    .init_done_out(init_done));
  sct_dram sct_dram_inst(.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
    .bus(bus_if), .read_latency_out(rl), .burst_length_setting_out(burst_len),
    .clk_active_out(clk_act));
  sct_monitor sct_monitor_inst(.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
    .cke(bus_if.cke), .cmd_n(bus_if.cmd_n), .addr(bus_if.addr),
    .dqm(bus_if.dqm), .dq_c_oe(bus_if.dq_c_oe), .dq_d_oe(bus_if.dq_d_oe));

  task automatic check(input string what, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // reset, then count cycles until the controller reports init done
  task automatic reset_init();
    int n;
    n = 0;
    nrst_in = 1'b0;
    repeat (16) @(negedge sys_clk_in);
    check("init_done in reset", {31'h0, init_done}, 32'h0);
    check("cmd in reset", {28'h0, bus_if.cmd_n},
      {28'h0, `SCT_CMD_NOP});
    nrst_in = 1'b1;
    while (init_done !== 1'b1 && n < 6000) begin
      @(negedge sys_clk_in);
      n++;
    end
    check("init long", {31'h0, n >= 4000 && n < 6000}, 32'h1);
    check("latency", {29'h0, rl}, {29'h0, `SCT_LAT2});
    check("burst", {28'h0, burst_len}, 32'h1);
    check("clk active", {31'h0, clk_act}, 32'h1);
  endtask

  // request is held until a negedge sees ready, then taken next posedge
  task automatic req(input logic w, input logic [1:0] b,
                     input logic [7:0] c, input logic [31:0] d,
                     input logic [3:0] m);
    int n;
    n = 0;
    @(negedge sys_clk_in);
    req_valid = 1'b1;
    req_write = w;
    req_bank = b;
    req_col = c;
    req_wdata = d;
    req_mask = m;
    while (req_ready !== 1'b1 && n < 2000) begin
      @(negedge sys_clk_in);
      n++;
    end
    check("ready", {31'h0, req_ready}, 32'h1);
    @(negedge sys_clk_in);
    req_valid = 1'b0;
  endtask

  task automatic rd(input int i);
    req(1'b0, i[1:0], 8'h10 + i[7:0], 32'h0, 4'h0);
    repeat (4) @(negedge sys_clk_in);
    check("rdata_valid", {31'h0, rdata_valid}, 32'h1);
    check("rdata", rdata, exp_mem[i]);
  endtask

  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end

  initial begin
    repeat (30000) @(posedge sys_clk_in);
    error_cnt++;
    wrap_up();
  end

  initial begin
    {req_valid, req_write, req_bank, req_col, req_wdata, req_mask} = '0;
    error_cnt = 0;
    cmp_count = 0;
    reset_init();
    for (int i = 0; i < 4; i++) begin
      exp_mem[i] = 32'h5AC3_0000 | i;
      req(1'b1, i[1:0], 8'h10 + i[7:0], exp_mem[i], 4'h0);
    end
    for (int i = 0; i < 4; i++) rd(i);
    // bytes 0 and 2 masked keep the old contents
    req(1'b1, 2'h1, 8'h11, 32'h1234_5678, 4'h5);
    exp_mem[1] = {8'h12, exp_mem[1][23:16], 8'h56, exp_mem[1][7:0]};
    rd(1);
    repeat (1500) @(negedge sys_clk_in);
    for (int i = 0; i < 4; i++) rd(i);
    reset_init();
    exp_mem[2] = 32'hC33C_A55A;
    req(1'b1, 2'h2, 8'h12, exp_mem[2], 4'h0);
    rd(2);
    wrap_up();
  end
endmodule
